// [include/lbp_pkg.sv]
// Package: register map, field positions and carrier types of the bus block
package lbp_pkg;

   // ------------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------------
   localparam int          NREG       = 42;
   localparam logic [31:0] BLOCK_BASE = 32'h0000_5000;
   localparam logic [15:0] MAP_LAST   = 16'hFFFF;

   typedef enum logic [1:0] {
      LBP_ACC_RW  = 2'b00,
      LBP_ACC_W1C = 2'b01,
      LBP_ACC_RO  = 2'b10
   } lbp_access_type;

   // Byte offsets, one entry per register; reset values are separate constants below
   localparam logic [15:0] REG_OFS [NREG] = '{
      16'h0000, 16'h0004, 16'h0008, 16'h000C, 16'h0010, 16'h0014,
      16'h0018, 16'h001C, 16'h0020, 16'h0024, 16'h0028, 16'h002C,
      16'h0030, 16'h0034, 16'h0038, 16'h003C, 16'h0068, 16'h0070,
      16'h0074, 16'h0078, 16'h0084, 16'h0088, 16'h0090, 16'h00A0,
      16'h00B0, 16'h00B4, 16'h00B8, 16'h00BC, 16'h00C0, 16'h00C4,
      16'h00D0, 16'h00D4, 16'h00E0, 16'h00E4, 16'h00E8, 16'h00EC,
      16'h00F0, 16'h00F4, 16'h0100, 16'h0104, 16'h0108, 16'h010C};

   localparam logic [31:0] BANK0_BASE_RST = 32'h0000_0001;
   localparam logic [31:0] BANK0_OPT_RST  = 32'h0000_0FF7;
   localparam logic [31:0] BUS_CONFIG_RST = 32'h0000_0000;
   localparam logic [31:0] CLK_RATIO_RST  = 32'h8000_0004;
   localparam logic [31:0] NAND_MODE_RST  = 32'h0000_0000;
   localparam logic [31:0] ZERO_RST       = 32'h0000_0000;

   localparam int IDX_BANK0_BASE = 0;
   localparam int IDX_BANK0_OPT  = 1;
   localparam int IDX_ERR_STATUS = 24;
   localparam int IDX_ERR_ECC    = 29;
   localparam int IDX_BUS_CONFIG = 30;
   localparam int IDX_CLK_RATIO  = 31;
   localparam int IDX_NAND_MODE  = 32;
   localparam int IDX_ECC_FIRST  = 38;
   localparam int NUM_ECC        = 4;
   localparam logic [15:0] OFS_ERR_STATUS = 16'h00B0;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int         MSEL_LSB      = 5;
   localparam logic [2:0] MSEL_NAND     = 3'h1;
   localparam int         CFG_ODD_BIT   = 0;
   localparam int         ERR_PAR_BIT   = 2;
   localparam int         CLKDIV_W      = 5;
   localparam logic [4:0] CLKDIV_MIN    = 5'h02;
   localparam logic [1:0] PS_8BIT       = 2'h1;
   localparam logic [1:0] PS_16BIT      = 2'h2;
   localparam logic [4:0] SRC_IDLE      = 5'h1F;

   // ------------------------------------------------------------------
   // Carrier types
   // ------------------------------------------------------------------
   typedef struct packed {
      logic        ale;        // Address phase of a transaction
      logic        ale_last;   // Last cycle of the address phase
      logic        addr_full;  // Address carries every physical bit
      logic        ad_oe;      // Block drives the muxed bus
      logic [31:0] ad_out;     // Address or write data for the bus
      logic        rd_sample;  // Read data is taken this cycle
      logic        ta;         // Internal data transfer acknowledge
      logic [2:0]  bank;       // Bank of the current access
      logic [1:0]  port_size;  // 1: 8 bit, 2: 16 bit, 3: 32 bit
      logic [4:0]  addr_src;   // Requester of the address
      logic [4:0]  data_src;   // Requester of the data beat
   } lbp_cycle_type;

   typedef struct packed {
      logic        valid;      // One-cycle pulse with read data
      logic [31:0] data;
      logic        par_err;    // Lane parity mismatch on this read
   } lbp_rdata_type;

endpackage

// [src/lbp_top.sv]
// Local bus parity, clock replicas, debug outputs and register file
//
// The strobed register port was decided locally.
`timescale 1ns/1ps

//Contract
// - Write parity is one bit per byte lane; line 0 is the top byte.
// - Parity drives and checks only on non-NAND-machine banks.
// - Parity of unused lanes of narrow ports is ignored.
// - Read parity sampled on the same edge as read data.
// - Parity lines switch impedance together with the muxed bus.
// - All three bus clock outputs carry one identical waveform.
// - Loop output replicates bus clock; board returns it to loop input.
// - Debug read: data valid high the cycle before data sampling.
// - Debug write: data valid high in the last valid write cycle.
// - Debug bursts pulse data valid once per beat.
// - Data valid only in debug mode, following internal acknowledge.
// - Debug source outputs stay high unless carrying an identifier.
// - Address identifier at last ALE cycle, data identifier with valid.
// - Address identifier only when the bus holds a full address.
// - Register block spans offsets 0x0000 to 0xFFFF, rest reserved.
// - Error status clears by writing one; reset zero.
// - Error ECC register clears by writing one; reset zero.
// - Four ECC result registers are read-only, reset zero.
// - ALE goes with the address; no other control during it.
module lbp_top #(
   parameter int LANES = 4
) (
   input  wire logic                 clk_sys,
   input  wire logic                 rst,
   // Register port
   input  wire logic [15:0]          reg_addr,
   input  wire logic [31:0]          reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output logic      [31:0]          reg_rdata,
   // Bus cycles from the chip-select machines
   input  wire lbp_pkg::lbp_cycle_type cyc,
   input  wire logic                 debug_mode,
   input  wire logic [31:0]          err_events,
   input  wire logic [31:0]          ecc_events,
   input  wire logic [lbp_pkg::NUM_ECC*32-1:0] ecc_results,
   output lbp_pkg::lbp_rdata_type    rdata,
   output logic      [31:0]          bus_config,
   // External pins
   output logic                      address_latch_enable,
   output logic      [31:0]          muxed_addr_data_bus_o,
   output logic                      muxed_addr_data_bus_oe,
   input  wire logic [31:0]          muxed_addr_data_bus_i,
   output logic      [LANES-1:0]     lane_parity_o,
   output logic                      lane_parity_oe,
   input  wire logic [LANES-1:0]     lane_parity_i,
   output logic      [2:0]           bus_clock_outputs,
   output logic                      clock_loop_out,
   input  wire logic                 clock_loop_in,
   output logic                      clock_loop_rise,
   output logic                      debug_data_valid,
   output logic      [4:0]           debug_source_id
);

   // ------------------------------------------------------------------
   // Register storage and decode
   // ------------------------------------------------------------------
   logic [31:0] regs_reg [lbp_pkg::NREG];
   logic [5:0]  hit_idx;
   logic        hit;
   logic        par_err_evt;
   logic [31:0] status_set;

   // Offset lookup; unaligned and unlisted offsets fall into reserved space
   always_comb begin
      hit     = 1'b0;
      hit_idx = 6'h00;
      for (int i = 0; i < lbp_pkg::NREG; i++) begin
         if (reg_addr == lbp_pkg::REG_OFS[i]) begin
            hit     = 1'b1;
            hit_idx = 6'(i);
         end
      end
   end

   assign status_set = err_events
                     | (32'(par_err_evt) << lbp_pkg::ERR_PAR_BIT);

   // One flop bank per register; kind of access picked per entry
   for (genvar g = 0; g < lbp_pkg::NREG; g++) begin : g_reg
      localparam logic [31:0] RST =
         (g == lbp_pkg::IDX_BANK0_BASE) ? lbp_pkg::BANK0_BASE_RST :
         (g == lbp_pkg::IDX_BANK0_OPT)  ? lbp_pkg::BANK0_OPT_RST  :
         (g == lbp_pkg::IDX_BUS_CONFIG) ? lbp_pkg::BUS_CONFIG_RST :
         (g == lbp_pkg::IDX_CLK_RATIO)  ? lbp_pkg::CLK_RATIO_RST  :
         (g == lbp_pkg::IDX_NAND_MODE)  ? lbp_pkg::NAND_MODE_RST  :
                                          lbp_pkg::ZERO_RST;
      logic wr_hit;
      assign wr_hit = reg_wr && hit && (hit_idx == 6'(g));
      if (g == lbp_pkg::IDX_ERR_STATUS) begin : g_w1c_status
         // Hardware set beats a same-cycle clear
         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) regs_reg[g] <= RST;
            else regs_reg[g] <= status_set
               | (regs_reg[g] & ~(wr_hit ? reg_wdata : 32'h0000_0000));
         end
      end else if (g == lbp_pkg::IDX_ERR_ECC) begin : g_w1c_ecc
         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) regs_reg[g] <= RST;
            else regs_reg[g] <= ecc_events
               | (regs_reg[g] & ~(wr_hit ? reg_wdata : 32'h0000_0000));
         end
      end else if (g >= lbp_pkg::IDX_ECC_FIRST) begin : g_ro
         // Results follow the flash machine; software writes are dropped
         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) regs_reg[g] <= RST;
            else regs_reg[g] <=
               ecc_results[(g - lbp_pkg::IDX_ECC_FIRST) * 32 +: 32];
         end
      end else begin : g_rw
         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) regs_reg[g] <= RST;
            else if (wr_hit) regs_reg[g] <= reg_wdata;
         end
      end
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd && hit) begin
         reg_rdata <= regs_reg[hit_idx];
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

   assign bus_config = regs_reg[lbp_pkg::IDX_BUS_CONFIG];

   // ------------------------------------------------------------------
   // Parity generation and bus drive
   // ------------------------------------------------------------------
   logic       odd_par;
   logic [2:0] bank_msel;
   logic       par_en;
   logic [LANES-1:0] par_gen;

   assign odd_par   = bus_config[lbp_pkg::CFG_ODD_BIT];
   assign bank_msel =
      regs_reg[2 * cyc.bank][lbp_pkg::MSEL_LSB +: 3];
   assign par_en    = (bank_msel != lbp_pkg::MSEL_NAND);

   // Lane 0 is the most significant byte of the bus
   for (genvar l = 0; l < LANES; l++) begin : g_par
      assign par_gen[l] = (^cyc.ad_out[31 - 8 * l -: 8]) ^ odd_par;
   end

   // Data and parity share one flop stage, so impedance changes line up
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         muxed_addr_data_bus_o  <= 32'h0000_0000;
         muxed_addr_data_bus_oe <= 1'b0;
         lane_parity_o          <= '0;
         lane_parity_oe         <= 1'b0;
      end else begin
         muxed_addr_data_bus_o  <= cyc.ad_out;
         muxed_addr_data_bus_oe <= cyc.ad_oe;
         lane_parity_o          <= par_gen;
         lane_parity_oe         <= cyc.ad_oe && par_en;
      end
   end

   // Address latch enable rides with the address drive
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) address_latch_enable <= 1'b0;
      else address_latch_enable <= cyc.ale;
   end

   // ------------------------------------------------------------------
   // Read capture and parity check
   // ------------------------------------------------------------------
   logic [31:0]      ad_s1_reg, ad_s2_reg;
   logic [LANES-1:0] par_s1_reg, par_s2_reg;
   logic [LANES-1:0] lane_used;
   logic [LANES-1:0] lane_bad;

   // Bus and parity pins pass the same two stages, keeping them aligned
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ad_s1_reg  <= 32'h0000_0000;
         ad_s2_reg  <= 32'h0000_0000;
         par_s1_reg <= '0;
         par_s2_reg <= '0;
      end else begin
         ad_s1_reg  <= muxed_addr_data_bus_i;
         ad_s2_reg  <= ad_s1_reg;
         par_s1_reg <= lane_parity_i;
         par_s2_reg <= par_s1_reg;
      end
   end

   // Narrow ports leave the lower lanes undefined; they are not checked
   for (genvar l = 0; l < LANES; l++) begin : g_chk
      assign lane_used[l] =
         (cyc.port_size == lbp_pkg::PS_8BIT)  ? (l == 0) :
         (cyc.port_size == lbp_pkg::PS_16BIT) ? (l < 2)  : 1'b1;
      assign lane_bad[l] = lane_used[l]
         && (((^ad_s2_reg[31 - 8 * l -: 8]) ^ par_s2_reg[l]) != odd_par);
   end

   assign par_err_evt = cyc.rd_sample && par_en && (|lane_bad);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rdata <= '0;
      end else begin
         rdata.valid   <= cyc.rd_sample;
         rdata.par_err <= par_err_evt;
         if (cyc.rd_sample) rdata.data <= ad_s2_reg;
      end
   end

   // ------------------------------------------------------------------
   // Bus clock divider and loop return
   // ------------------------------------------------------------------
   logic [lbp_pkg::CLKDIV_W-1:0] div_cnt_reg;
   logic [lbp_pkg::CLKDIV_W-1:0] div_ratio;
   logic [lbp_pkg::CLKDIV_W-1:0] half_cnt;
   logic                         bus_clk_reg;
   logic                         loop_s1_reg, loop_s2_reg, loop_s3_reg;

   // Ratios below the minimum would wrap the half-count compare to 31, so they are clamped
   assign div_ratio =
      (regs_reg[lbp_pkg::IDX_CLK_RATIO][lbp_pkg::CLKDIV_W-1:0]
         < lbp_pkg::CLKDIV_MIN) ? lbp_pkg::CLKDIV_MIN
      : regs_reg[lbp_pkg::IDX_CLK_RATIO][lbp_pkg::CLKDIV_W-1:0];
   assign half_cnt = div_ratio >> 1;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         div_cnt_reg <= '0;
         bus_clk_reg <= 1'b0;
      end else if (div_cnt_reg >= half_cnt - 5'h01) begin
         div_cnt_reg <= '0;
         bus_clk_reg <= ~bus_clk_reg;
      end else begin
         div_cnt_reg <= div_cnt_reg + 5'h01;
      end
   end

   // One flop feeds every replica, so no skew between loads
   assign bus_clock_outputs = {3{bus_clk_reg}};
   assign clock_loop_out    = bus_clk_reg;

   // Returned loop clock is sampled; the rise pulse shows the loop is closed
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         loop_s1_reg <= 1'b0;
         loop_s2_reg <= 1'b0;
         loop_s3_reg <= 1'b0;
      end else begin
         loop_s1_reg <= clock_loop_in;
         loop_s2_reg <= loop_s1_reg;
         loop_s3_reg <= loop_s2_reg;
      end
   end
   assign clock_loop_rise = loop_s2_reg && !loop_s3_reg;

   // ------------------------------------------------------------------
   // Debug data valid and source identifier
   // ------------------------------------------------------------------
   logic dv_next;
   logic addr_id_next;

   // Acknowledge never counts during the address phase
   assign dv_next      = debug_mode && cyc.ta && !cyc.ale;
   assign addr_id_next = debug_mode && cyc.ale_last && cyc.addr_full;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         debug_data_valid <= 1'b0;
         debug_source_id  <= lbp_pkg::SRC_IDLE;
      end else begin
         debug_data_valid <= dv_next;
         if (dv_next) begin
            debug_source_id <= cyc.data_src;
         end else if (addr_id_next) begin
            debug_source_id <= cyc.addr_src;
         end else begin
            debug_source_id <= lbp_pkg::SRC_IDLE;
         end
      end
   end

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence par_clear_s;
      reg_wr && (reg_addr == lbp_pkg::OFS_ERR_STATUS)
         && reg_wdata[lbp_pkg::ERR_PAR_BIT] && !par_err_evt
         && !err_events[lbp_pkg::ERR_PAR_BIT];
   endsequence

   sequence par_err_s;
      par_err_evt;
   endsequence

   lane_zero_parity_a: assert property (
      lane_parity_oe |-> lane_parity_o[0]
         == ((^muxed_addr_data_bus_o[31:24]) ^ $past(odd_par)))
      else $error("lane 0 parity wrong");

   nand_no_parity_a: assert property (
      $past(bank_msel == lbp_pkg::MSEL_NAND) |-> !lane_parity_oe)
      else $error("parity driven on nand bank");

   parity_impedance_a: assert property (
      lane_parity_oe |-> muxed_addr_data_bus_oe)
      else $error("parity driven without bus");

   clock_copy_a: assert property (
      (bus_clock_outputs == {3{clock_loop_out}}))
      else $error("bus clock replicas differ");

   dv_follows_ack_a: assert property (
      (debug_mode && cyc.ta && !cyc.ale) |=> debug_data_valid)
      else $error("data valid missing after acknowledge");

   dv_cause_a: assert property (
      debug_data_valid |-> $past(debug_mode) && $past(cyc.ta))
      else $error("data valid without acknowledge");

   src_idle_a: assert property (
      !debug_data_valid && !$past(addr_id_next)
         |-> debug_source_id == lbp_pkg::SRC_IDLE)
      else $error("source id not high when idle");

   src_data_a: assert property (
      debug_data_valid |-> debug_source_id == $past(cyc.data_src))
      else $error("source id not data requester");

   status_clear_a: assert property (
      par_clear_s |=> !regs_reg[lbp_pkg::IDX_ERR_STATUS][lbp_pkg::ERR_PAR_BIT])
      else $error("status bit not cleared");

   status_set_a: assert property (
      par_err_s |=> regs_reg[lbp_pkg::IDX_ERR_STATUS][lbp_pkg::ERR_PAR_BIT])
      else $error("parity error not recorded");

   reserved_read_a: assert property (
      (reg_rd && !hit) |=> reg_rdata == 32'h0000_0000)
      else $error("reserved read not zero");

   ale_alone_a: assert property (
      address_latch_enable |-> !debug_data_valid)
      else $error("data valid during address latch");

   read_capture_a: assert property (
      cyc.rd_sample |=> rdata.valid && rdata.data == $past(ad_s2_reg))
      else $error("read data not captured");

   narrow_lane_a: assert property (
      cyc.rd_sample && cyc.port_size == lbp_pkg::PS_8BIT
         && (((^ad_s2_reg[31:24]) ^ par_s2_reg[0]) == odd_par)
         |=> !rdata.par_err)
      else $error("unused lane parity checked");

   addr_source_a: assert property (
      addr_id_next && !dv_next |=> debug_source_id == $past(cyc.addr_src))
      else $error("source id not address requester");

   parity_follow_a: assert property (
      muxed_addr_data_bus_oe && $past(par_en) |-> lane_parity_oe)
      else $error("bus driven without parity");

endmodule // lbp_top

// [test/lbp_mem_model.sv]
// Model of the memory on the muxed bus and of the board clock loop
`timescale 1ns/1ps
module lbp_mem_model (
   input  wire logic        clk_sys,
   input  wire logic        drive,
   input  wire logic [31:0] word,
   input  wire logic        odd,
   input  wire logic [3:0]  flip,
   input  wire logic        clock_loop_out,
   output logic      [31:0] bus_i,
   output logic      [3:0]  par_i,
   output logic             clock_loop_in
);
   logic [31:0] last_reg = 32'h5A5A_A5A5;

   // Remember the last driven word so a released bus never shows it again
   always @(posedge clk_sys) begin
      if (drive) begin
         last_reg <= word;
      end
   end

   // Read data with lane parity; flip corrupts chosen lanes on purpose
   always_comb begin
      bus_i = drive ? word : ~last_reg;
      for (int l = 0; l < 4; l++) begin
         par_i[l] = ^bus_i[31-8*l -: 8] ^ odd ^ flip[l];
      end
   end

   // Passive loop: board delay only, no other load on the output
   assign #7 clock_loop_in = clock_loop_out;
endmodule // lbp_mem_model

// [test/tb.sv]
// Self-checking bench of the bus block against a model of the memory side
`timescale 1ns/1ps
module tb;
   logic                   clk_sys = 1'b0;
   logic                   rst = 1'b1;
   logic [15:0]            reg_addr = 16'h0000;
   logic [31:0]            reg_wdata = 32'h0000_0000;
   logic                   reg_wr = 1'b0, reg_rd = 1'b0;
   logic [31:0]            reg_rdata, bus_config, ad_o, ad_i;
   lbp_pkg::lbp_cycle_type cyc = '0;
   lbp_pkg::lbp_rdata_type rdata;
   logic                   debug_mode = 1'b0;
   logic [31:0]            err_events = 32'h0, ecc_events = 32'h0;
   logic [127:0]           ecc_results = 128'h0;
   logic                   ale_pin, ad_oe, par_oe, loop_out, loop_in, rise;
   logic [3:0]             par_o, par_i, flip = 4'h0, fl;
   logic [2:0]             bclk;
   logic                   dval, m_drive = 1'b0, m_odd = 1'b0, e, dbg, nb;
   logic [4:0]             src_id, s;
   logic [31:0]            m_word = 32'h0, d, x, w;
   logic [1:0]             ps;
   logic [15:0]            rsv [6] = '{16'h0040, 16'h006C, 16'h00FC,
                                       16'h0110, 16'hFFFC, 16'h0006};
   int                     fails = 0, checks_done = 0, ticks = 0, n, last;

   // ------------------------------------------------------------------
   // Clock, design and memory model
   // ------------------------------------------------------------------
   initial begin
      forever #2 clk_sys = ~clk_sys;
   end
   lbp_top lbp_top_inst (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .cyc(cyc), .debug_mode(debug_mode),
      .err_events(err_events), .ecc_events(ecc_events),
      .ecc_results(ecc_results), .rdata(rdata), .bus_config(bus_config),
      .address_latch_enable(ale_pin), .muxed_addr_data_bus_o(ad_o),
      .muxed_addr_data_bus_oe(ad_oe), .muxed_addr_data_bus_i(ad_i),
      .lane_parity_o(par_o), .lane_parity_oe(par_oe),
      .lane_parity_i(par_i), .bus_clock_outputs(bclk),
      .clock_loop_out(loop_out), .clock_loop_in(loop_in),
      .clock_loop_rise(rise), .debug_data_valid(dval),
      .debug_source_id(src_id));
   lbp_mem_model lbp_mem_model_inst (.clk_sys(clk_sys), .drive(m_drive),
      .word(m_word), .odd(m_odd), .flip(flip), .clock_loop_out(loop_out),
      .bus_i(ad_i), .par_i(par_i), .clock_loop_in(loop_in));

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      if (fails == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] v);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   // Read data is looked at only in the one cycle where it stands
   task automatic rd(input logic [15:0] a, output logic [31:0] v);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      v = reg_rdata;
   endtask
   // Release the bus cycle and settle where registered pins are stable
   task automatic tick();
      @(posedge clk_sys);
      cyc <= '0;
      @(negedge clk_sys);
   endtask
   function automatic logic [31:0] rst_val(input int i);
      case (i)
         lbp_pkg::IDX_BANK0_BASE: return lbp_pkg::BANK0_BASE_RST;
         lbp_pkg::IDX_BANK0_OPT:  return lbp_pkg::BANK0_OPT_RST;
         lbp_pkg::IDX_BUS_CONFIG: return lbp_pkg::BUS_CONFIG_RST;
         lbp_pkg::IDX_CLK_RATIO:  return lbp_pkg::CLK_RATIO_RST;
         lbp_pkg::IDX_NAND_MODE:  return lbp_pkg::NAND_MODE_RST;
         default:                 return lbp_pkg::ZERO_RST;
      endcase
   endfunction
   function automatic logic [3:0] par(input logic [31:0] v, input logic o);
      for (int l = 0; l < 4; l++) begin
         par[l] = ^v[31-8*l -: 8] ^ o;
      end
   endfunction

   // Cut a hang short
   always @(posedge clk_sys) begin
      ticks++;
      if (ticks == 20000) begin
         fails++;
         wrap_up();
      end
   end

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      void'($urandom(32'h5b105457));
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      // Reset values, then write and read back by access kind
      for (int i = 0; i < lbp_pkg::NREG; i++) begin
         rd(lbp_pkg::REG_OFS[i], d);
         chk(d, rst_val(i));
      end
      for (int i = 0; i < lbp_pkg::NREG; i++) begin
         w = $urandom();
         w[4] = 1'b1;
         wr(lbp_pkg::REG_OFS[i], w);
         rd(lbp_pkg::REG_OFS[i], d);
         nb = (i == lbp_pkg::IDX_ERR_STATUS) || (i == lbp_pkg::IDX_ERR_ECC)
              || (i >= lbp_pkg::IDX_ECC_FIRST);
         chk(d, nb ? 32'h0 : w);
      end
      foreach (rsv[k]) begin
         wr(rsv[k], 32'hFFFF_FFFF);
         rd(rsv[k], d);
         chk(d, 32'h0);
      end
      // Hardware sets status bits; only bits written as one are cleared
      w = $urandom();
      @(posedge clk_sys);
      err_events <= w;
      ecc_events <= ~w;
      ecc_results <= {$urandom(), $urandom(), $urandom(), $urandom()};
      @(posedge clk_sys);
      err_events <= 32'h0;
      ecc_events <= 32'h0;
      x = $urandom();
      wr(16'h00B0, x);
      wr(16'h00C4, x);
      rd(16'h00B0, d);
      chk(d, w & ~x);
      rd(16'h00C4, d);
      chk(d, ~w & ~x);
      for (int k = 0; k < 4; k++) begin
         wr(16'(16'h0100 + 4 * k), 32'hFFFF_FFFF);
         rd(16'(16'h0100 + 4 * k), d);
         chk(d, ecc_results[32*k +: 32]);
      end
      // Bank 0 on the chip-select machine, bank 3 on the NAND machine
      wr(16'h0000, 32'h0000_0001);
      wr(16'h0018, 32'h0000_0020);
      // Divide by 20 gives an 80 ns bus clock; loop edges every 20 cycles
      wr(16'h00D4, 32'h8000_0014);
      n = 0;
      for (int i = 0; i < 200; i++) begin
         @(negedge clk_sys);
         chk(bclk, {3{loop_out}});
         if (rise === 1'b1) begin
            if (n >= 2) chk(i - last, 20);
            n++;
            last = i;
         end
      end
      // Write parity for both polarities and both machine kinds
      for (int p = 0; p < 4; p++) begin
         wr(16'h00D0, {31'h0, p[0]});
         w = $urandom();
         @(posedge clk_sys);
         cyc.ad_oe <= 1'b1;
         cyc.ad_out <= w;
         cyc.bank <= p[1] ? 3'h3 : 3'h0;
         cyc.port_size <= 2'h3;
         tick();
         chk(bus_config, {31'h0, p[0]});
         chk({ad_oe, ad_o}, {1'b1, w});
         chk(par_oe, !p[1]);
         if (!p[1]) chk(par_o, par(w, p[0]));
         @(negedge clk_sys);
         chk({ad_oe, par_oe}, 2'b00);
      end
      // Read parity across port widths, corrupted lanes and machines
      for (int t = 0; t < 24; t++) begin
         ps = 2'(1 + t % 3);
         nb = (t % 8 == 7);
         wr(16'h00D0, {31'h0, t[1]});
         wr(16'h00B0, 32'hFFFF_FFFF);
         w = $urandom();
         fl = 4'($urandom());
         if (t == 3) fl = 4'hE;
         if (nb) fl = 4'hF;
         @(posedge clk_sys);
         m_drive <= 1'b1;
         m_word <= w;
         m_odd <= t[1];
         flip <= fl;
         repeat (3) @(posedge clk_sys);
         cyc.rd_sample <= 1'b1;
         cyc.bank <= nb ? 3'h3 : 3'h0;
         cyc.port_size <= ps;
         tick();
         e = !nb && |(fl & ((ps == 2'h1) ? 4'h1 : (ps == 2'h2) ? 4'h3 : 4'hF));
         chk({rdata.valid, rdata.data}, {1'b1, w});
         chk(rdata.par_err, e);
         @(posedge clk_sys);
         m_drive <= 1'b0;
         rd(16'h00B0, d);
         chk(d[lbp_pkg::ERR_PAR_BIT], e);
      end
      // Debug identifiers for address and data, and idle level outside
      for (int t = 0; t < 12; t++) begin
         s = 5'($urandom());
         w = $urandom();
         dbg = (t < 10);
         @(posedge clk_sys);
         debug_mode <= dbg;
         if (t[0]) begin
            cyc.ale <= 1'b1;
            cyc.ale_last <= 1'b1;
            cyc.addr_full <= t[1];
            cyc.addr_src <= s;
            cyc.ad_oe <= 1'b1;
            cyc.ad_out <= w;
         end else begin
            cyc.ta <= 1'b1;
            cyc.data_src <= s;
         end
         tick();
         chk(src_id, !dbg ? 5'h1F : (t[0] && !t[1]) ? 5'h1F : s);
         chk(dval, dbg && !t[0]);
         if (t[0]) chk({ale_pin, ad_o}, {1'b1, w});
         @(negedge clk_sys);
         chk({dval, src_id}, 6'h1F);
      end
      // A burst of four beats with a gap gives four valid pulses
      n = 0;
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_sys);
         debug_mode <= 1'b1;
         cyc.ta <= (i < 5) && (i != 2);
         @(negedge clk_sys);
         n += int'(dval === 1'b1);
      end
      chk(n, 4);
      wrap_up();
   end
endmodule // tb
